// ===== blcf_backlight_ctrl.sv
// backlight sink control: registers, pulse gating and current fade
`timescale 1ns/10ps
`default_nettype none
`include "blcf_params.svh"

module blcf_backlight_ctrl
  import blcf_pkg::*;
#(
  parameter int FADE_SLOW_CYC = `BLCF_FADE_SLOW_CYC,
  parameter int FADE_FAST_CYC = `BLCF_FADE_FAST_CYC,
  parameter logic [6:0] DEV_ADDR = `BLCF_SERIAL_ADDR
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // serial port pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // general purpose pins
  input wire logic [2:0] gpio_in,
  output logic [2:0] gpio_out,
  output logic [2:0] gpio_oe,
  // sink drive
  output blcf_byte_t primary_level,
  output logic primary_on,
  output blcf_byte_t secondary_level,
  output logic secondary_on,
  output logic fade_busy
);

  // ==========================================================
  // serial port
  logic wr_stb;
  blcf_byte_t wr_addr, wr_data, rd_addr;
  blcf_byte_t rd_data_reg;

  blcf_serial_port #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .mclk(mclk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data_reg)
  );

  assign sda_out = 1'b0;

  // ==========================================================
  // register file
  blcf_byte_t ctrl_reg, pri_level_reg, sec_level_reg;
  blcf_byte_t gpio_ctrl_reg, gpio_data_reg, pulse_gate_reg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= `BLCF_RESET_VALUE;
      pri_level_reg <= `BLCF_RESET_VALUE;
      sec_level_reg <= `BLCF_RESET_VALUE;
      gpio_ctrl_reg <= `BLCF_RESET_VALUE;
      gpio_data_reg <= `BLCF_RESET_VALUE;
      pulse_gate_reg <= `BLCF_RESET_VALUE;
    end
    else if (wr_stb)
    begin
      case (wr_addr)
        `BLCF_ADDR_CTRL: ctrl_reg <= wr_data & `BLCF_MASK_CTRL;
        `BLCF_ADDR_PRI_LEVEL: pri_level_reg <= wr_data;
        `BLCF_ADDR_SEC_LEVEL: sec_level_reg <= wr_data;
        `BLCF_ADDR_GPIO_CTRL: gpio_ctrl_reg <= wr_data & `BLCF_MASK_GPIO_CTRL;
        `BLCF_ADDR_GPIO_DATA: gpio_data_reg <= wr_data & `BLCF_MASK_GPIO_DATA;
        `BLCF_ADDR_PULSE_GATE: pulse_gate_reg <= wr_data & `BLCF_MASK_PULSE_GATE;
        default: ;
      endcase
    end
  end

  logic slope_fast, fade_sel, fade_en, joined_drive_select, pri_en, sec_en;
  assign slope_fast = ctrl_reg[`BLCF_CTRL_SLOPE];
  assign fade_sel = ctrl_reg[`BLCF_CTRL_FADE_SEL];
  assign fade_en = ctrl_reg[`BLCF_CTRL_FADE_EN];
  assign joined_drive_select = ctrl_reg[`BLCF_CTRL_JOINED];
  assign pri_en = ctrl_reg[`BLCF_CTRL_PRI_EN];
  assign sec_en = ctrl_reg[`BLCF_CTRL_SEC_EN];

  // ==========================================================
  // general purpose pins and pulse input
  logic [2:0] gpio_s1_reg, gpio_s2_reg;
  logic pulse_pin_en, pulse_level;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gpio_s1_reg <= 3'h0;
      gpio_s2_reg <= 3'h0;
    end
    else
    begin
      gpio_s1_reg <= gpio_in;
      gpio_s2_reg <= gpio_s1_reg;
    end
  end

  assign pulse_pin_en = gpio_ctrl_reg[`BLCF_GPIO_PULSE_PIN_EN];
  // pin zero is forced to input while it carries the pulse
  assign gpio_oe = {gpio_ctrl_reg[2:1], gpio_ctrl_reg[0] & ~pulse_pin_en};
  assign gpio_out = gpio_data_reg[2:0];
  // a disabled pulse pin reads as low, so gated sinks stay dark
  assign pulse_level = pulse_pin_en & gpio_s2_reg[0];

  // ==========================================================
  // register read back; the data register shows the pin levels
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data_reg <= 8'h00;
    else
    begin
      case (rd_addr)
        `BLCF_ADDR_CTRL: rd_data_reg <= ctrl_reg;
        `BLCF_ADDR_PRI_LEVEL: rd_data_reg <= pri_level_reg;
        `BLCF_ADDR_SEC_LEVEL: rd_data_reg <= sec_level_reg;
        `BLCF_ADDR_GPIO_CTRL: rd_data_reg <= gpio_ctrl_reg;
        `BLCF_ADDR_GPIO_DATA: rd_data_reg <= {5'h00, gpio_s2_reg};
        `BLCF_ADDR_PULSE_GATE: rd_data_reg <= pulse_gate_reg;
        default: rd_data_reg <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // fade step timer
  logic pri_faded, sec_faded, pri_moving, sec_moving, step_tick;
  blcf_byte_t pri_app_reg, sec_app_reg;
  logic [19:0] step_cnt_reg;
  logic [19:0] step_last;

  assign pri_faded = fade_en & ~fade_sel;
  assign sec_faded = fade_en & fade_sel & ~joined_drive_select;
  assign pri_moving = pri_faded && (pri_app_reg != pri_level_reg);
  assign sec_moving = sec_faded && (sec_app_reg != sec_level_reg);
  assign step_last = slope_fast ? 20'(FADE_FAST_CYC - 1) : 20'(FADE_SLOW_CYC - 1);
  assign step_tick = (step_cnt_reg == step_last);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      step_cnt_reg <= 20'h00000;
    else if (!(pri_moving || sec_moving) || step_tick)
      step_cnt_reg <= 20'h00000;
    else
      step_cnt_reg <= step_cnt_reg + 20'h00001;
  end

  // ==========================================================
  // applied current codes: ramp one count per tick, or follow at once
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pri_app_reg <= 8'h00;
    else if (!pri_faded)
      pri_app_reg <= pri_level_reg;
    else if (step_tick && pri_app_reg < pri_level_reg)
      pri_app_reg <= pri_app_reg + 8'h01;
    else if (step_tick && pri_app_reg > pri_level_reg)
      pri_app_reg <= pri_app_reg - 8'h01;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      sec_app_reg <= 8'h00;
    else if (!sec_faded)
      sec_app_reg <= sec_level_reg;
    else if (step_tick && sec_app_reg < sec_level_reg)
      sec_app_reg <= sec_app_reg + 8'h01;
    else if (step_tick && sec_app_reg > sec_level_reg)
      sec_app_reg <= sec_app_reg - 8'h01;
  end

  // ==========================================================
  // sink outputs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      primary_level <= 8'h00;
      secondary_level <= 8'h00;
      primary_on <= 1'b0;
      secondary_on <= 1'b0;
      fade_busy <= 1'b0;
    end
    else
    begin
      primary_level <= pri_app_reg;
      secondary_level <= joined_drive_select ? pri_app_reg : sec_app_reg;
      primary_on <= pri_en & (~pulse_gate_reg[`BLCF_GATE_PRI] | pulse_level);
      secondary_on <= sec_en & (~pulse_gate_reg[`BLCF_GATE_SEC] | pulse_level);
      fade_busy <= pri_moving | sec_moving;
    end
  end

endmodule

`default_nettype wire

// ===== blcf_ctrl_monitor.sv
// port checker for the backlight controller
`timescale 1ns/10ps
`default_nettype none
`include "blcf_params.svh"

module blcf_ctrl_monitor
  import blcf_pkg::*;
#(
  parameter int FADE_SLOW_CYC = `BLCF_FADE_SLOW_CYC,
  parameter int FADE_FAST_CYC = `BLCF_FADE_FAST_CYC
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // serial pins
  input wire logic scl_in,
  input wire logic sda_oe,
  // sink drive
  input wire blcf_byte_t primary_level,
  input wire logic primary_on,
  input wire blcf_byte_t secondary_level,
  input wire logic secondary_on,
  input wire logic fade_busy
);
  int stall_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // cycles spent fading without a step
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      stall_cnt <= 0;
    else if (fade_busy && $stable(primary_level) && $stable(secondary_level))
      stall_cnt <= stall_cnt + 1;
    else
      stall_cnt <= 0;
  end
  sequence lvl_move;
    $changed(primary_level) || $changed(secondary_level);
  endsequence
  sequence lvl_hold;
    ($stable(primary_level) && $stable(secondary_level)) [*3];
  endsequence
  // ==========================================================
  // properties
  reset_clear_a: assert property ($rose(rst_n) |-> !primary_on && !secondary_on
    && primary_level == 8'h00 && secondary_level == 8'h00 && !fade_busy)
    else $error("outputs not clear after reset");
  ack_phase_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data pin moved while clock high");
  ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("data pin pull too short");
  pri_step_a: assert property (fade_busy && $past(fade_busy) && !scl_in
    && $changed(primary_level) |-> primary_level == $past(primary_level) + 8'h01
    || primary_level == $past(primary_level) - 8'h01) else $error("primary jumped");
  sec_step_a: assert property (fade_busy && $past(fade_busy) && !scl_in
    && $changed(secondary_level) |-> secondary_level == $past(secondary_level) + 8'h01
    || secondary_level == $past(secondary_level) - 8'h01) else $error("secondary jumped");
  step_gap_a: assert property ((fade_busy && !scl_in) ##0 lvl_move |=> lvl_hold)
    else $error("fade steps too close");
  ramp_stall_a: assert property (stall_cnt <= FADE_SLOW_CYC + 2)
    else $error("fade stalled");
  write_phase_a: assert property ((!fade_busy && !$past(fade_busy)) ##0 lvl_move
    |-> scl_in) else $error("level changed outside acknowledge");
endmodule

bind blcf_backlight_ctrl blcf_ctrl_monitor #(
  .FADE_SLOW_CYC(FADE_SLOW_CYC),
  .FADE_FAST_CYC(FADE_FAST_CYC)
) u_blcf_ctrl_monitor (
  .mclk(mclk), .rst_n(rst_n), .scl_in(scl_in), .sda_oe(sda_oe),
  .primary_level(primary_level), .primary_on(primary_on),
  .secondary_level(secondary_level), .secondary_on(secondary_on), .fade_busy(fade_busy)
);
`default_nettype wire

// ===== blcf_far_side.sv
// far side model: led strings, pulse source and pin pull-ups
`timescale 1ns/10ps
`default_nettype none

module blcf_far_side
  import blcf_pkg::*;
(
  // pulse source and pins
  input wire logic pulse,
  input wire logic [2:0] gpio_out,
  input wire logic [2:0] gpio_oe,
  output logic [2:0] gpio_pin,
  // sinks
  input wire blcf_byte_t primary_level,
  input wire logic primary_on,
  input wire blcf_byte_t secondary_level,
  input wire logic secondary_on,
  output blcf_byte_t pri_ma10,
  output blcf_byte_t sec_ma10
);
  assign gpio_pin[0] = gpio_oe[0] ? gpio_out[0] : pulse;
  assign gpio_pin[2:1] = gpio_out[2:1] | ~gpio_oe[2:1];
  assign pri_ma10 = primary_on ? primary_level : 8'h00;
  assign sec_ma10 = secondary_on ? secondary_level : 8'h00;
endmodule
`default_nettype wire

// ===== blcf_params.svh
// constants for the backlight current and fade controller
`ifndef BLCF_PARAMS_SVH
`define BLCF_PARAMS_SVH

// ==========================================================
// register addresses
`define BLCF_ADDR_CTRL 8'h03
`define BLCF_ADDR_PRI_LEVEL 8'h04
`define BLCF_ADDR_SEC_LEVEL 8'h05
`define BLCF_ADDR_GPIO_CTRL 8'h06
`define BLCF_ADDR_GPIO_DATA 8'h07
`define BLCF_ADDR_PULSE_GATE 8'h2b

// ==========================================================
// writable bit masks and reset values
`define BLCF_MASK_CTRL 8'h3f
`define BLCF_MASK_GPIO_CTRL 8'h17
`define BLCF_MASK_GPIO_DATA 8'h07
`define BLCF_MASK_PULSE_GATE 8'h03
`define BLCF_RESET_VALUE 8'h00

// ==========================================================
// field positions
`define BLCF_CTRL_SLOPE 5
`define BLCF_CTRL_FADE_SEL 4
`define BLCF_CTRL_FADE_EN 3
`define BLCF_CTRL_JOINED 2
`define BLCF_CTRL_PRI_EN 1
`define BLCF_CTRL_SEC_EN 0
`define BLCF_GPIO_PULSE_PIN_EN 4
`define BLCF_GATE_PRI 0
`define BLCF_GATE_SEC 1

// ==========================================================
// timing
`define BLCF_MCLK_PERIOD_NS 50
`define BLCF_FADE_SLOW_NS 1300000000
`define BLCF_FADE_FAST_NS 650000000
`define BLCF_FADE_STEPS 255
`define BLCF_FADE_SLOW_CYC (`BLCF_FADE_SLOW_NS / (`BLCF_MCLK_PERIOD_NS * `BLCF_FADE_STEPS))
`define BLCF_FADE_FAST_CYC (`BLCF_FADE_FAST_NS / (`BLCF_MCLK_PERIOD_NS * `BLCF_FADE_STEPS))

// ==========================================================
// serial port
`define BLCF_SERIAL_ADDR 7'h59

`endif

// ===== blcf_pkg.sv
// types shared by the backlight controller files
package blcf_pkg;

  typedef logic [7:0] blcf_byte_t;

  typedef enum logic [3:0] {
    SP_IDLE,
    SP_ADDR,
    SP_ACK_ADDR,
    SP_REG,
    SP_ACK_REG,
    SP_WDATA,
    SP_ACK_WDATA,
    SP_RDATA,
    SP_MACK
  } blcf_sp_state_t;

endpackage

// ===== blcf_serial_port.sv
// two-wire serial slave that turns bus transfers into register strobes
`timescale 1ns/10ps
`default_nettype none
`include "blcf_params.svh"

module blcf_serial_port
  import blcf_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `BLCF_SERIAL_ADDR
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  // register side
  output logic wr_stb,
  output blcf_byte_t wr_addr,
  output blcf_byte_t wr_data,
  output blcf_byte_t rd_addr,
  input wire blcf_byte_t rd_data
);

  // ==========================================================
  // pin synchronisers
  logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= 3'h7;
      {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= 3'h7;
    end
    else
    begin
      {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= {scl_in, scl_s1_reg, scl_s2_reg};
      {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= {sda_in, sda_s1_reg, sda_s2_reg};
    end
  end

  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise = scl_s2_reg & ~scl_s3_reg;
  assign scl_fall = ~scl_s2_reg & scl_s3_reg;
  assign start_cond = scl_s2_reg & scl_s3_reg & ~sda_s2_reg & sda_s3_reg;
  assign stop_cond = scl_s2_reg & scl_s3_reg & sda_s2_reg & ~sda_s3_reg;

  // ==========================================================
  // protocol engine
  blcf_sp_state_t state_reg;
  logic [3:0] cnt_reg;
  blcf_byte_t shift_reg;
  blcf_byte_t ptr_reg;
  logic stb_reg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= SP_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      stb_reg <= 1'b0;
    end
    else
    begin
      stb_reg <= 1'b0;
      if (start_cond)
      begin
        state_reg <= SP_ADDR;
        cnt_reg <= 4'h0;
      end
      else if (stop_cond)
        state_reg <= SP_IDLE;
      else
      begin
        case (state_reg)
          SP_ADDR, SP_REG, SP_WDATA:
          begin
            if (scl_rise)
            begin
              shift_reg <= {shift_reg[6:0], sda_s2_reg};
              cnt_reg <= cnt_reg + 4'h1;
            end
            else if (scl_fall && cnt_reg == 4'h8)
            begin
              cnt_reg <= 4'h0;
              if (state_reg == SP_REG)
              begin
                ptr_reg <= shift_reg;
                state_reg <= SP_ACK_REG;
              end
              else if (state_reg == SP_WDATA)
                state_reg <= SP_ACK_WDATA;
              else if (shift_reg[7:1] == DEV_ADDR)
                state_reg <= SP_ACK_ADDR;
              else
                state_reg <= SP_IDLE;
            end
          end
          SP_ACK_ADDR:
          begin
            if (scl_fall)
            begin
              cnt_reg <= 4'h0;
              if (shift_reg[0])
              begin
                shift_reg <= rd_data;
                state_reg <= SP_RDATA;
              end
              else
                state_reg <= SP_REG;
            end
          end
          SP_ACK_REG:
          begin
            if (scl_fall)
              state_reg <= SP_WDATA;
          end
          SP_ACK_WDATA:
          begin
            // write lands on the rising clock edge of this acknowledge
            if (scl_rise)
            begin
              stb_reg <= 1'b1;
            end
            if (stb_reg)
              ptr_reg <= ptr_reg + 8'h01;
            if (scl_fall)
              state_reg <= SP_WDATA;
          end
          SP_RDATA:
          begin
            if (scl_fall)
            begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              cnt_reg <= cnt_reg + 4'h1;
              if (cnt_reg == 4'h7)
                state_reg <= SP_MACK;
            end
          end
          SP_MACK:
          begin
            if (scl_rise)
            begin
              if (sda_s2_reg)
                state_reg <= SP_IDLE;
              else
                ptr_reg <= ptr_reg + 8'h01;
            end
            else if (scl_fall)
            begin
              cnt_reg <= 4'h0;
              shift_reg <= rd_data;
              state_reg <= SP_RDATA;
            end
          end
          default:
            state_reg <= SP_IDLE;
        endcase
      end
    end
  end

  assign sda_oe = (state_reg == SP_ACK_ADDR) || (state_reg == SP_ACK_REG)
    || (state_reg == SP_ACK_WDATA) || (state_reg == SP_RDATA && !shift_reg[7]);
  assign wr_stb = stb_reg;
  assign wr_addr = ptr_reg;
  assign wr_data = shift_reg;
  assign rd_addr = ptr_reg;

endmodule

`default_nettype wire

// ===== blcf_testbench.sv
// self-checking bench for the backlight controller
`timescale 1ns/10ps
`default_nettype none
`include "blcf_params.svh"

module testbench
  import blcf_pkg::*;
();
  localparam blcf_byte_t SLOW = 8'h08;
  localparam blcf_byte_t FAST = 8'h04;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic pulse = 1'b0;
  wire logic sda;
  logic sda_oe, sda_out, primary_on, secondary_on, fade_busy;
  logic [2:0] gpio_pin, gpio_out, gpio_oe;
  blcf_byte_t primary_level, secondary_level, pri_ma10, sec_ma10, pl_q, sl_q, rd_v;
  int miscompares = 0;
  int checks = 0;
  int pc, sc, pg, sg, gp, gs;
  // open-drain data line: the device drives its data output only while enabled
  assign sda = sda_oe ? sda_out : sda_m;
  always #25 mclk = !mclk;

  blcf_backlight_ctrl #(
    .FADE_SLOW_CYC(int'(SLOW)),
    .FADE_FAST_CYC(int'(FAST))
  ) u_blcf_backlight_ctrl (
    .mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .gpio_in(gpio_pin), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .primary_level(primary_level), .primary_on(primary_on),
    .secondary_level(secondary_level), .secondary_on(secondary_on), .fade_busy(fade_busy)
  );
  blcf_far_side u_blcf_far_side (
    .pulse(pulse), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_pin(gpio_pin),
    .primary_level(primary_level), .primary_on(primary_on), .secondary_level(secondary_level),
    .secondary_on(secondary_on), .pri_ma10(pri_ma10), .sec_ma10(sec_ma10)
  );

  // ==========================================================
  // step counters and spacing of level changes
  always @(posedge mclk)
  begin
    pl_q <= primary_level;
    sl_q <= secondary_level;
    pc <= pc + int'(primary_level !== pl_q);
    pg <= (primary_level !== pl_q) ? gp : pg;
    gp <= (primary_level !== pl_q) ? 1 : gp + 1;
    sc <= sc + int'(secondary_level !== sl_q);
    sg <= (secondary_level !== sl_q) ? gs : sg;
    gs <= (secondary_level !== sl_q) ? 1 : gs + 1;
  end

  // ==========================================================
  // tasks
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input string what, input blcf_byte_t exp, input blcf_byte_t got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic sbit(input logic b, output logic r);
    sda_m = b;
    w(8);
    scl = 1'b1;
    w(10);
    r = sda;
    scl = 1'b0;
    w(2);
  endtask
  task automatic start();
    sda_m = 1'b1;
    w(8);
    scl = 1'b1;
    w(10);
    sda_m = 1'b0;
    w(10);
    scl = 1'b0;
    w(2);
  endtask
  task automatic stop();
    sda_m = 1'b0;
    w(8);
    scl = 1'b1;
    w(10);
    sda_m = 1'b1;
    w(10);
  endtask
  task automatic send(input blcf_byte_t d);
    logic r;
    for (int i = 7; i >= 0; i--)
      sbit(d[i], r);
    sbit(1'b1, r);
    chk("ack", 8'h00, {7'h00, r});
  endtask
  task automatic wr(input blcf_byte_t a, input blcf_byte_t d);
    start();
    send({`BLCF_SERIAL_ADDR, 1'b0});
    send(a);
    send(d);
    stop();
  endtask
  task automatic rdchk(input blcf_byte_t a, input blcf_byte_t e);
    logic r;
    start();
    send({`BLCF_SERIAL_ADDR, 1'b0});
    send(a);
    start();
    send({`BLCF_SERIAL_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--)
    begin
      sbit(1'b1, r);
      rd_v[i] = r;
    end
    sbit(1'b1, r);
    stop();
    chk("register", e, rd_v);
  endtask
  task automatic ramp(input blcf_byte_t a, input blcf_byte_t d);
    pc = 0;
    sc = 0;
    wr(a, d);
    for (int i = 0; i < 600 && fade_busy !== 1'b0; i++)
      w(1);
    // the last step reaches the outputs with busy low; let the step counters see it
    w(2);
    chk("fade done", 8'h00, {7'h00, fade_busy});
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // watchdog and main sequence
  initial
  begin
    repeat (80000) @(posedge mclk);
    miscompares++;
    summarize();
  end
  initial
  begin
    w(6);
    rst_n = 1'b1;
    w(4);
    chk("pri level", 8'h00, primary_level);
    rdchk(8'h03, 8'h00);
    rdchk(8'h04, 8'h00);
    rdchk(8'h40, 8'h00);
    wr(8'h04, 8'h21);
    wr(8'h05, 8'h10);
    wr(8'h03, 8'h02);
    chk("pri mA", 8'h21, pri_ma10);
    chk("sec off", 8'h00, sec_ma10);
    wr(8'h03, 8'h01);
    chk("sec mA", 8'h10, sec_ma10);
    chk("pri off", 8'h00, pri_ma10);
    wr(8'h03, 8'h07);
    chk("joined", 8'h21, sec_ma10);
    rdchk(8'h05, 8'h10);
    wr(8'h03, 8'h03);
    chk("split", 8'h10, sec_ma10);
    wr(8'h06, 8'h11);
    chk("pin dir", 8'h00, {5'h00, gpio_oe});
    wr(8'h2b, 8'h01);
    chk("gate low", 8'h00, pri_ma10);
    chk("ungated", 8'h10, sec_ma10);
    pulse = 1'b1;
    w(4);
    chk("gate high", 8'h21, pri_ma10);
    wr(8'h2b, 8'h02);
    pulse = 1'b0;
    w(4);
    chk("sec gated", 8'h00, sec_ma10);
    chk("pri free", 8'h21, pri_ma10);
    wr(8'h06, 8'h01);
    pulse = 1'b1;
    w(4);
    chk("pin off", 8'h00, sec_ma10);
    chk("pin out", 8'h01, {5'h00, gpio_oe});
    wr(8'h07, 8'h05);
    chk("pin data", 8'h05, {5'h00, gpio_out});
    rdchk(8'h07, 8'h07);
    wr(8'h2b, 8'h00);
    wr(8'h03, 8'h2b);
    ramp(8'h04, 8'h25);
    chk("fast steps", 8'h04, pc[7:0]);
    chk("fast gap", FAST, pg[7:0]);
    chk("fast end", 8'h25, pri_ma10);
    chk("sec idle", 8'h00, sc[7:0]);
    wr(8'h03, 8'h0b);
    ramp(8'h04, 8'h1f);
    chk("slow steps", 8'h06, pc[7:0]);
    chk("slow gap", SLOW, pg[7:0]);
    chk("fade down", 8'h1f, pri_ma10);
    wr(8'h03, 8'h1b);
    ramp(8'h05, 8'h13);
    chk("sec steps", 8'h03, sc[7:0]);
    chk("sec gap", SLOW, sg[7:0]);
    ramp(8'h04, 8'h30);
    chk("pri jump", 8'h01, pc[7:0]);
    wr(8'h03, 8'h0f);
    ramp(8'h04, 8'h33);
    chk("both steps", 8'h03, sc[7:0]);
    chk("both end", 8'h33, sec_ma10);
    wr(8'h03, 8'h03);
    ramp(8'h04, 8'h80);
    chk("no fade", 8'h01, pc[7:0]);
    wr(8'h03, 8'h1f);
    ramp(8'h04, 8'h40);
    chk("joined sel1", 8'h01, sc[7:0]);
    chk("joined jump", 8'h40, sec_ma10);
    summarize();
  end
endmodule
`default_nettype wire
